/* File: shared/dobc_pkg.sv */
package dobc_pkg;

  // option byte locations as indices; byte address is four times the index
  localparam logic [19:0] IDX_RSVD     = 20'h000c2;
  localparam logic [19:0] IDX_DBG      = 20'h000c3;
  localparam logic [19:0] IDX_RSVD_ALT = 20'h010c2;
  localparam logic [19:0] IDX_DBG_ALT  = 20'h010c3;
  localparam logic [31:0] ADDR_RSVD     = {10'h000, IDX_RSVD, 2'h0};
  localparam logic [31:0] ADDR_DBG      = {10'h000, IDX_DBG, 2'h0};
  localparam logic [31:0] ADDR_RSVD_ALT = {10'h000, IDX_RSVD_ALT, 2'h0};
  localparam logic [31:0] ADDR_DBG_ALT  = {10'h000, IDX_DBG_ALT, 2'h0};
  localparam logic [31:0] ADDR_STATUS   = 32'h0000_0000;

  // slots of the option byte store
  localparam logic [1:0] SLOT_RSVD     = 2'h0;
  localparam logic [1:0] SLOT_DBG      = 2'h1;
  localparam logic [1:0] SLOT_RSVD_ALT = 2'h2;
  localparam logic [1:0] SLOT_DBG_ALT  = 2'h3;

  // debug option byte fields
  localparam int          DBG_EN_BIT   = 7;
  localparam int          SUPP_BIT     = 0;
  localparam int          SCR_LSB      = 1;
  localparam int          SCR_MSB      = 3;
  localparam logic [5:0]  FIXED_BITS   = 6'h02;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;

  // status register fields
  localparam int ST_EN_BIT   = 0;
  localparam int ST_ERASE_BIT = 1;
  localparam int ST_DONE_BIT = 2;
  localparam int ST_SWAP_BIT = 3;
  localparam int ST_BAD_BIT  = 4;
  localparam int ST_BYTE_LSB = 8;

  // bus timing: access cycles before pready, minus one
  localparam logic [1:0] APB_WAIT = 2'h1;

  typedef enum logic [1:0] {ST_BOOT, ST_FETCH, ST_WAIT, ST_RUN} dobc_state_t;

endpackage

/* File: rtl/dobc_store.sv */
`timescale 1ns/100ps
module dobc_store
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       we,
  input  wire logic [1:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [1:0] raddr,
  output logic      [7:0] rdata
);

  typedef struct packed {
    logic [3:0][7:0] mem;
    logic [7:0]      rdata;
  } dobc_store_t;

  dobc_store_t s_r;
  dobc_store_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdata = s_r.mem[raddr];
    if (we)
    begin
      s_nxt.mem[waddr] = wdata;
    end
  end

  // erased state of the store
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= {{4{dobc_pkg::ERASED_BYTE}}, dobc_pkg::ERASED_BYTE};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;

endmodule // dobc_store

/* File: rtl/dobc_top.sv */
// How it works
// - both bits zero disables debug entirely
// - enable, no suppress: debug on, erase on fail
// - enable and suppress: debug on, keep flash
// - debugger may overwrite bits three to one
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module dobc_top
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        boot_swap,
  input  wire logic        auth_fail,
  input  wire logic        scratch_we,
  input  wire logic [2:0]  scratch_bits,
  output logic             ocd_enable,
  output logic             erase_on_fail,
  output logic             flash_erase_req,
  output logic             load_done
);

  typedef struct packed {
    dobc_pkg::dobc_state_t st;
    logic                  swap;
    logic [7:0]            dbg_byte;
    logic [7:0]            act_byte;
    logic                  ocd_en;
    logic                  erase_en;
    logic                  bad_code;
    logic                  done;
    logic                  erase_req;
    logic [1:0]            wcnt;
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
  } dobc_regs_t;

  dobc_regs_t r_r;
  dobc_regs_t r_nxt;

  logic       mem_we;
  logic [1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic       acc;
  logic       wr_done;
  logic [2:0] dec;

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // {hit_store, slot}
  function automatic logic [2:0] addr_dec(input logic [31:0] a);
    case (a)
      dobc_pkg::ADDR_RSVD:     addr_dec = {1'b1, dobc_pkg::SLOT_RSVD};
      dobc_pkg::ADDR_DBG:      addr_dec = {1'b1, dobc_pkg::SLOT_DBG};
      dobc_pkg::ADDR_RSVD_ALT: addr_dec = {1'b1, dobc_pkg::SLOT_RSVD_ALT};
      dobc_pkg::ADDR_DBG_ALT:  addr_dec = {1'b1, dobc_pkg::SLOT_DBG_ALT};
      default:                 addr_dec = 3'h0;
    endcase
  endfunction

  // {debug on, erase on auth fail, prohibited code}
  function automatic logic [2:0] opt_dec(input logic [7:0] b);
    logic en;
    logic supp;
    en = b[dobc_pkg::DBG_EN_BIT];
    supp = b[dobc_pkg::SUPP_BIT];
    opt_dec = {en, en & ~supp, ~en & supp};
  endfunction

  // store slot of the active debug byte
  function automatic logic [1:0] act_slot(input logic swap);
    act_slot = swap ? dobc_pkg::SLOT_DBG_ALT : dobc_pkg::SLOT_DBG;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // option byte store

  assign acc = psel & penable;
  assign dec = addr_dec(paddr);
  assign wr_done = acc & r_r.pready & pwrite & dec[2];

  always_comb
  begin
    mem_raddr = dec[1:0];
    if (r_r.st != dobc_pkg::ST_RUN)
    begin
      mem_raddr = act_slot(r_r.swap);
    end
    mem_we = 1'b0;
    mem_waddr = dec[1:0];
    mem_wdata = pwdata[7:0];
    if (wr_done)
    begin
      mem_we = 1'b1;
    end
    else if (scratch_we && r_r.ocd_en && r_r.st == dobc_pkg::ST_RUN)
    begin
      mem_we = 1'b1;
      mem_waddr = act_slot(r_r.swap);
      // other bits of the stored byte are kept
      mem_wdata = {r_r.act_byte[7:4], scratch_bits, r_r.act_byte[0]};
    end
  end

  dobc_store u_store
  (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // loader, decode and bus

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.erase_req = 1'b0;
    case (r_r.st)
      dobc_pkg::ST_BOOT:
      begin
        r_nxt.swap = boot_swap;
        r_nxt.st = dobc_pkg::ST_FETCH;
      end
      dobc_pkg::ST_FETCH:
      begin
        r_nxt.st = dobc_pkg::ST_WAIT;
      end
      dobc_pkg::ST_WAIT:
      begin
        r_nxt.dbg_byte = mem_rdata;
        r_nxt.act_byte = mem_rdata;
        {r_nxt.ocd_en, r_nxt.erase_en, r_nxt.bad_code} = opt_dec(mem_rdata);
        r_nxt.done = 1'b1;
        r_nxt.st = dobc_pkg::ST_RUN;
      end
      dobc_pkg::ST_RUN:
      begin
        r_nxt.erase_req = auth_fail & r_r.erase_en;
        if (mem_we && !wr_done)
        begin
          r_nxt.dbg_byte[dobc_pkg::SCR_MSB:dobc_pkg::SCR_LSB] = scratch_bits;
          r_nxt.act_byte[dobc_pkg::SCR_MSB:dobc_pkg::SCR_LSB] = scratch_bits;
        end
        // shadow of stored active byte follows bus writes
        if (wr_done && dec[1:0] == act_slot(r_r.swap))
        begin
          r_nxt.act_byte = pwdata[7:0];
        end
      end
      default:
      begin
        r_nxt.st = dobc_pkg::ST_BOOT;
      end
    endcase

    if (r_r.pready)
    begin
      r_nxt.pready = 1'b0;
      r_nxt.pslverr = 1'b0;
      r_nxt.wcnt = 2'h0;
    end
    else if (acc && r_r.st == dobc_pkg::ST_RUN)
    begin
      if (r_r.wcnt == dobc_pkg::APB_WAIT)
      begin
        r_nxt.pready = 1'b1;
        r_nxt.prdata = 32'h0000_0000;
        r_nxt.pslverr = 1'b0;
        if (dec[2])
        begin
          r_nxt.prdata = {24'h000000, mem_rdata};
        end
        else if (paddr == dobc_pkg::ADDR_STATUS)
        begin
          r_nxt.prdata[dobc_pkg::ST_EN_BIT] = r_r.ocd_en;
          r_nxt.prdata[dobc_pkg::ST_ERASE_BIT] = r_r.erase_en;
          r_nxt.prdata[dobc_pkg::ST_DONE_BIT] = r_r.done;
          r_nxt.prdata[dobc_pkg::ST_SWAP_BIT] = r_r.swap;
          r_nxt.prdata[dobc_pkg::ST_BAD_BIT] = r_r.bad_code;
          r_nxt.prdata[dobc_pkg::ST_BYTE_LSB +: 8] = r_r.dbg_byte;
        end
        else
        begin
          r_nxt.pslverr = 1'b1;
        end
      end
      else
      begin
        r_nxt.wcnt = r_r.wcnt + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_r <= '{st: dobc_pkg::ST_BOOT, dbg_byte: 8'h00, act_byte: 8'h00, prdata: 32'h0000_0000,
               wcnt: 2'h0, default: 1'b0};
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign prdata = r_r.prdata;
  assign pready = r_r.pready;
  assign pslverr = r_r.pslverr;
  assign ocd_enable = r_r.ocd_en;
  assign erase_on_fail = r_r.erase_en;
  assign flash_erase_req = r_r.erase_req;
  assign load_done = r_r.done;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  ocd_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_r.done && !r_r.dbg_byte[dobc_pkg::DBG_EN_BIT] |-> !ocd_enable && !erase_on_fail)
    else $error("debug active with enable bit clear");

  bad_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    auth_fail && r_r.bad_code |=> !flash_erase_req)
    else $error("prohibited code produced an erase");

  erase_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_r.st == dobc_pkg::ST_RUN && auth_fail && ocd_enable
      && !r_r.dbg_byte[dobc_pkg::SUPP_BIT] |=> flash_erase_req)
    else $error("failed id did not request erase");

  keep_flash_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_r.done && r_r.dbg_byte[dobc_pkg::SUPP_BIT] |-> ##1 !flash_erase_req)
    else $error("erase requested while suppressed");

  dbg_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_r.done && r_r.dbg_byte[dobc_pkg::DBG_EN_BIT] |-> ocd_enable)
    else $error("debug off with enable bit set");

  scratch_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_r.st == dobc_pkg::ST_RUN && scratch_we && ocd_enable && !wr_done
      |=> r_r.dbg_byte[3:1] == $past(scratch_bits) ##1 u_store.s_r.mem[$past(mem_waddr, 2)][3:1]
      == $past(scratch_bits, 2))
    else $error("debugger bits not stored");

  load_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_r.st == dobc_pkg::ST_BOOT |-> ##3 load_done && r_r.st == dobc_pkg::ST_RUN)
    else $error("option load not done in three cycles");

  swap_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_r.st == dobc_pkg::ST_FETCH |-> mem_raddr == (r_r.swap ? dobc_pkg::SLOT_DBG_ALT
      : dobc_pkg::SLOT_DBG))
    else $error("wrong option byte location fetched");

  hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    load_done ##1 load_done |-> $stable(ocd_enable) && $stable(erase_on_fail))
    else $error("debug settings changed after load");

  bus_ans_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |-> ##[1:5] pready)
    else $error("bus access not answered");

  keep_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    mem_we && !wr_done |=> u_store.s_r.mem[$past(mem_waddr)][7:4]
      == $past(u_store.s_r.mem[mem_waddr][7:4])
      && u_store.s_r.mem[$past(mem_waddr)][0] == $past(u_store.s_r.mem[mem_waddr][0]))
    else $error("debugger write changed other bits");

  erase_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
    flash_erase_req |-> erase_on_fail && $past(auth_fail))
    else $error("erase request without failed id");

  slv_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready && !dec[2] && paddr != dobc_pkg::ADDR_STATUS |-> pslverr)
    else $error("unmapped access without error");

endmodule // dobc_top

/* File: verification/dobc_tool.sv */
`timescale 1ns/100ps
module dobc_tool
(
  input  wire logic pclk,
  output logic      auth_fail,
  output logic      scratch_we,
  output logic [2:0] scratch_bits
);
  initial
  begin
    auth_fail = 1'b0;
    scratch_we = 1'b0;
    scratch_bits = 3'h5;
  end
  ////////////////////////////////////////////////////////////////
  // failed id check, one cycle
  task automatic fail_auth();
    auth_fail <= 1'b1;
    @(posedge pclk);
    auth_fail <= 1'b0;
  endtask
  task automatic rewrite(input logic [2:0] v);
    scratch_we <= 1'b1;
    scratch_bits <= v;
    @(posedge pclk);
    scratch_we <= 1'b0;
    scratch_bits <= ~v;
  endtask
endmodule // dobc_tool

/* File: verification/debug_option_byte_config_bench.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module debug_option_byte_config_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        boot_swap = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, err, sw;
  logic        auth_fail, scratch_we, ocd_enable, erase_on_fail;
  logic        flash_erase_req, load_done;
  logic [2:0]  scratch_bits, v;
  logic [7:0]  mem [4];
  logic [7:0]  samp, c;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          seed = 32'h27f56f5c;
  localparam logic [31:0] AT [4] = '{dobc_pkg::ADDR_RSVD, dobc_pkg::ADDR_DBG,
    dobc_pkg::ADDR_RSVD_ALT, dobc_pkg::ADDR_DBG_ALT};
  // codes with fixed bits, never 8'h05
  localparam logic [7:0] CODES [3] = '{8'h04, 8'h84, 8'h85};

  always #2 pclk = ~pclk;

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  dobc_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_swap(boot_swap),
    .auth_fail(auth_fail), .scratch_we(scratch_we), .scratch_bits(scratch_bits),
    .ocd_enable(ocd_enable), .erase_on_fail(erase_on_fail),
    .flash_erase_req(flash_erase_req), .load_done(load_done));

  dobc_tool tool (.pclk(pclk), .auth_fail(auth_fail), .scratch_we(scratch_we),
    .scratch_bits(scratch_bits));

  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK("pready", 1'b1, pready)
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("read", e, rd)
    `CHK("slverr", 1'b0, err)
  endtask

  function automatic logic [31:0] st();
    return {16'h0, samp, 3'h0, 1'b0, sw, 3'h5};
  endfunction

  ////////////////////////////////////////////////////////////////
  initial
  begin
    for (int r = 0; r < 3; r++)
    begin
      sw = r[0];
      presetn <= 1'b0;
      boot_swap <= sw;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (mem[i]) mem[i] = 8'hff;
      samp = 8'hff;
      repeat (2) @(posedge pclk);
      #1 `CHK("load_done", 1'b0, load_done)
      @(posedge pclk);
      #1 `CHK("load_done", 1'b1, load_done)
      `CHK("ocd_enable", 1'b1, ocd_enable)
      `CHK("erase_on_fail", 1'b0, erase_on_fail)
      @(posedge pclk);
      tool.fail_auth();
      #1 `CHK("flash_erase_req", 1'b0, flash_erase_req)
      @(posedge pclk);
      rdchk(dobc_pkg::ADDR_STATUS, st());
      for (int k = 0; k < 4; k++)
      begin
        c = CODES[$unsigned($random(seed)) % 3];
        mem[1] = c;
        mem[3] = c;
        for (int s = 0; s < 4; s++) apb(1'b1, AT[s], {24'h0, mem[s]});
        for (int s = 0; s < 4; s++) rdchk(AT[s], {24'h0, mem[s]});
        `CHK("ocd_enable", 1'b1, ocd_enable)
        `CHK("erase_on_fail", 1'b0, erase_on_fail)
        v = 3'($random(seed));
        tool.rewrite(v);
        mem[1 + 2 * sw][3:1] = v;
        samp[3:1] = v;
        rdchk(dobc_pkg::ADDR_STATUS, st());
        rdchk(AT[1 + 2 * sw], {24'h0, mem[1 + 2 * sw]});
      end
      apb(1'b0, 32'h4, 32'h0);
      `CHK("slverr", 1'b1, err)
      `CHK("read", 32'h0, rd)
      apb(1'b1, dobc_pkg::ADDR_STATUS, 32'h0);
      `CHK("slverr", 1'b0, err)
      rdchk(dobc_pkg::ADDR_STATUS, st());
      $display("test %0d done", r);
    end
    print_verdict();
  end
endmodule // debug_option_byte_config_bench
